// File: src/srk_reclocker_ctrl.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// How it works
// RL1: Speed code 00 auto-detects, 01 fixes 270 Mbps, 10 fixes 1483/1485 Mbps.
// RL2: 143 Mbps is accepted only under automatic rate detection.
// RL3: Speed selector resets to 00, so automatic detection is the default.
// RL4: Fixed 270 mode takes DVB-ASI and never locks on a harmonic.
// RL5: Input pick code 00..11 routes serial_in_0..serial_in_3 to the datapath.
// RL6: lock_indicator is high only with data present and the loop locked.
// RL7: silence_n low mutes the primary and second outputs.
// RL8: Muting wins over reclock_skip.
// RL9: silence_n resets high, so outputs are enabled by default.
// RL10: reclock_skip high passes data through without retiming.
// RL11: With skip low, bypass when unlocked or rate unsupported, else reclock.
// RL12: reclock_skip resets low, so automatic bypass is the default.
// RL13: silence_n following lock, locked and skip high: active and unretimed.
// RL14: definition_class high for 270/143 Mbps, low for 1483/1485 Mbps.
// RL15: definition_class is registered and forced low while unlocked.
// RL16: definition_class is valid eight reference periods after a lock edge.
// RL17: lock_indicator drops within 1 ms after the input signal stops.
// RL18: clock_out_choose high puts the recovered clock on second_output.
// RL19: clock_out_choose resets low, so second_output carries data by default.
// RL20: The system supplies the timing reference clock.
// RL21: Unmuted, skip low: bypass while unlocked, reclock while locked.
// RL22: second_output as clock is muted whenever bypass is active.
// RL23: 177, 360 and 540 Mbps are refused and bypassed.
// RL24: Muted outputs hold true and complement legs at opposite levels.
// RL25: Speed code 11 is a test mode: no lock, data passes unretimed.
// RL26: Pin inputs are synchronised; lock and rate come from a recovery model.
module srk_reclocker_ctrl #(
	parameter int LOSS_CYCLES = srk_pkg::LOSS_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic serial_in_0_in,
	input wire logic serial_in_1_in,
	input wire logic serial_in_2_in,
	input wire logic serial_in_3_in,
	input wire logic recov_clk_in,
	input wire logic cdr_locked_in,
	input wire logic [2:0] cdr_rate_in,
	output logic lock_indicator_out,
	output logic definition_class_out,
	output logic primary_output_p_out,
	output logic primary_output_n_out,
	output logic second_output_p_out,
	output logic second_output_n_out
);
	localparam int AW = $clog2(LOSS_CYCLES + 1);
	localparam int DW = $clog2(srk_pkg::DEF_CYCLES + 1);
	localparam logic [AW-1:0] LOSS_CNT = AW'(LOSS_CYCLES);
	localparam logic [DW-1:0] DEF_CNT = DW'(srk_pkg::DEF_CYCLES);

	logic [7:0] ctrl_q;
	logic [31:0] prdata_q;
	logic [3:0] ser_s1_q, ser_s2_q;
	logic rclk_s1_q, rclk_s2_q, rclk_s3_q;
	logic lock_s1_q, lock_s2_q;
	logic [2:0] rate_s1_q, rate_s2_q;
	srk_pkg::srk_rate_t rate_q, rate_held_q;
	logic raw_q, raw_prev_q, retimed_q;
	logic [3:0] cfg_prev_q;
	logic [AW-1:0] act_cnt_q;
	srk_pkg::srk_lock_st_t lock_st_q, lock_st_d;
	logic lock_q;
	logic [DW-1:0] def_cnt_q;
	logic def_q;
	logic pri_p_q, pri_n_q, sec_p_q, sec_n_q;
	srk_pkg::srk_speed_t speed;
	logic [1:0] pick;
	logic follow, silence_n, skip, clk_choose;
	logic lost, cfg_change, ok, bypass, mute, data_sel, sec_src;
	logic wr_en, rd_setup, addr_ok;

	// Control field decode
	assign speed = srk_pkg::srk_speed_t'(ctrl_q[srk_pkg::CTRL_SPEED_LSB +: 2]);
	assign pick = ctrl_q[srk_pkg::CTRL_PICK_LSB +: 2];
	assign follow = ctrl_q[srk_pkg::CTRL_FOLLOW_BIT];
	// Tying silence to lock is a wire on the board; here it is a control bit
	assign silence_n = follow ? lock_q : ctrl_q[srk_pkg::CTRL_SILENCE_BIT]; // RL13
	assign skip = ctrl_q[srk_pkg::CTRL_SKIP_BIT];
	assign clk_choose = ctrl_q[srk_pkg::CTRL_CLKSEL_BIT];

	// APB decode; zero wait states
	assign addr_ok = (paddr_in == srk_pkg::CTRL_OFS) || (paddr_in == srk_pkg::STAT_OFS);
	assign wr_en = psel_in && penable_in && pwrite_in;
	assign rd_setup = psel_in && !penable_in && !pwrite_in;
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !addr_ok;
	assign prdata_out = prdata_q;

	// Control register; reset values mimic the pin pulls
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ctrl_q <= srk_pkg::CTRL_RST; // RL3 RL9 RL12 RL19
		end else if (wr_en && paddr_in == srk_pkg::CTRL_OFS) begin
			ctrl_q <= pwdata_in[srk_pkg::CTRL_WIDTH-1:0];
		end
	end

	// Read data captured in setup, stable through the access phase
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_q <= 32'h0000_0000;
			if (paddr_in == srk_pkg::CTRL_OFS) begin
				prdata_q[srk_pkg::CTRL_WIDTH-1:0] <= ctrl_q;
			end else if (paddr_in == srk_pkg::STAT_OFS) begin
				prdata_q[srk_pkg::STAT_LOCK_BIT] <= lock_q;
				prdata_q[srk_pkg::STAT_DEF_BIT] <= def_q;
				prdata_q[srk_pkg::STAT_BYPASS_BIT] <= bypass;
				prdata_q[srk_pkg::STAT_MUTE_BIT] <= mute;
				prdata_q[srk_pkg::STAT_RATE_LSB +: 3] <= rate_q;
				prdata_q[srk_pkg::STAT_ACT_BIT] <= !lost;
			end
		end
	end

	// Two-flop synchronisers on every pin input
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ser_s1_q <= 4'h0;
			ser_s2_q <= 4'h0;
			rclk_s1_q <= 1'b0;
			rclk_s2_q <= 1'b0;
			rclk_s3_q <= 1'b0;
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
			rate_s1_q <= 3'h7;
			rate_s2_q <= 3'h7;
			rate_q <= srk_pkg::RATE_NONE;
		end else begin
			ser_s1_q <= {serial_in_3_in, serial_in_2_in, serial_in_1_in, serial_in_0_in}; // RL26
			ser_s2_q <= ser_s1_q;
			rclk_s1_q <= recov_clk_in;
			rclk_s2_q <= rclk_s1_q;
			rclk_s3_q <= rclk_s2_q;
			lock_s1_q <= cdr_locked_in;
			lock_s2_q <= lock_s1_q;
			rate_s1_q <= cdr_rate_in;
			rate_s2_q <= rate_s1_q;
			rate_q <= srk_pkg::srk_rate_t'(rate_s2_q);
		end
	end

	// Input multiplexer and retiming on recovered clock rising edges
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			raw_q <= 1'b0;
			raw_prev_q <= 1'b0;
			retimed_q <= 1'b0;
		end else begin
			raw_q <= ser_s2_q[pick]; // RL5
			raw_prev_q <= raw_q;
			if (rclk_s2_q && !rclk_s3_q) begin
				retimed_q <= raw_q;
			end
		end
	end

	// Activity watchdog: no transition for the loss time means no signal
	assign lost = (act_cnt_q == LOSS_CNT);
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			act_cnt_q <= LOSS_CNT;
		end else if (raw_q != raw_prev_q) begin
			act_cnt_q <= '0;
		end else if (!lost) begin
			act_cnt_q <= act_cnt_q + AW'(1); // RL17
		end
	end

	// Remember the selection to notice a change of input or speed
	assign cfg_change = (cfg_prev_q != {speed, pick});
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			cfg_prev_q <= 4'h0;
		end else begin
			cfg_prev_q <= {speed, pick};
		end
	end

	// Lock qualification: harmonics and odd rates never qualify
	assign ok = lock_s2_q && !lost && srk_pkg::rate_supported(speed, rate_q); // RL1 RL2 RL4 RL23 RL25

	always_comb begin
		lock_st_d = lock_st_q;
		case (lock_st_q)
			srk_pkg::LK_SEARCH: begin
				if (ok && !cfg_change) begin
					lock_st_d = srk_pkg::LK_LOCKED; // RL6
				end
			end
			srk_pkg::LK_LOCKED: begin
				if (!ok || cfg_change || rate_q != rate_held_q) begin
					lock_st_d = srk_pkg::LK_SEARCH; // RL6 RL17
				end
			end
			default: lock_st_d = srk_pkg::LK_SEARCH;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			lock_st_q <= srk_pkg::LK_SEARCH;
			rate_held_q <= srk_pkg::RATE_NONE;
		end else begin
			lock_st_q <= lock_st_d;
			if (lock_st_q == srk_pkg::LK_SEARCH) begin
				rate_held_q <= rate_q;
			end
		end
	end
	assign lock_q = (lock_st_q == srk_pkg::LK_LOCKED);
	assign lock_indicator_out = lock_q;

	// Definition class: settle delay after every lock edge, low when unlocked
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			def_cnt_q <= '0;
		end else if (lock_st_d != lock_st_q) begin
			def_cnt_q <= DEF_CNT; // RL16
		end else if (def_cnt_q != '0) begin
			def_cnt_q <= def_cnt_q - DW'(1);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			def_q <= 1'b0;
		end else if (!lock_q) begin
			def_q <= 1'b0; // RL15
		end else if (def_cnt_q == DW'(1)) begin
			def_q <= srk_pkg::rate_is_sd(rate_held_q); // RL14 RL16
		end
	end
	assign definition_class_out = def_q;

	// Bypass and mute decisions; mute is checked first so it always wins
	assign bypass = skip || !lock_q || (speed == srk_pkg::SPD_TEST); // RL10 RL11 RL21 RL25
	assign mute = !silence_n; // RL7 RL8
	assign data_sel = bypass ? raw_q : retimed_q; // RL10 RL13
	assign sec_src = clk_choose ? rclk_s2_q : data_sel; // RL18

	// Registered differential outputs; muted legs sit at 0/1
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pri_p_q <= 1'b0;
			pri_n_q <= 1'b1;
			sec_p_q <= 1'b0;
			sec_n_q <= 1'b1;
		end else begin
			if (mute) begin
				pri_p_q <= 1'b0; // RL7 RL8 RL24
				pri_n_q <= 1'b1;
			end else begin
				pri_p_q <= data_sel;
				pri_n_q <= !data_sel;
			end
			// A clock with no lock behind it is not worth sending
			if (mute || (clk_choose && bypass)) begin
				sec_p_q <= 1'b0; // RL22 RL24
				sec_n_q <= 1'b1;
			end else begin
				sec_p_q <= sec_src;
				sec_n_q <= !sec_src;
			end
		end
	end
	assign primary_output_p_out = pri_p_q;
	assign primary_output_n_out = pri_n_q;
	assign second_output_p_out = sec_p_q;
	assign second_output_n_out = sec_n_q;

	// Checks next to the logic they guard
	property p_pick_route;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		$stable(pick) |=> raw_q == $past(ser_s2_q[pick]);
	endproperty
	a_pick_route: assert property (p_pick_route) else $error("input pick routes wrong input"); // RL5

	property p_mute_static;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		mute |=> !pri_p_q && pri_n_q && !sec_p_q && sec_n_q;
	endproperty
	a_mute_static: assert property (p_mute_static) else $error("outputs not muted"); // RL7

	property p_mute_over_skip;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(mute && skip) [*2] |=> !primary_output_p_out && primary_output_n_out;
	endproperty
	a_mute_over_skip: assert property (p_mute_over_skip) else $error("skip overrode mute"); // RL8

	property p_skip_pass;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(skip && !mute) |=> pri_p_q == $past(raw_q) && pri_n_q != pri_p_q;
	endproperty
	a_skip_pass: assert property (p_skip_pass) else $error("skip did not pass raw data"); // RL10

	property p_auto_bypass;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!skip && !mute && lock_q && speed != srk_pkg::SPD_TEST) |=> pri_p_q == $past(retimed_q);
	endproperty
	a_auto_bypass: assert property (p_auto_bypass) else $error("locked data not retimed"); // RL11

	property p_def_low_unlocked;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!lock_q |=> !def_q;
	endproperty
	a_def_low_unlocked: assert property (p_def_low_unlocked) else $error("class high while unlocked"); // RL15

	property p_def_settle;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		$rose(lock_q) ##1 lock_q [*7] |=> def_q == srk_pkg::rate_is_sd(rate_held_q);
	endproperty
	a_def_settle: assert property (p_def_settle) else $error("class not valid after settle"); // RL16

	property p_loss_drop;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		lost |=> !lock_q;
	endproperty
	a_loss_drop: assert property (p_loss_drop) else $error("lock held without activity"); // RL17

	property p_clk_mute;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(clk_choose && bypass) |=> !sec_p_q && sec_n_q;
	endproperty
	a_clk_mute: assert property (p_clk_mute) else $error("clock output live in bypass"); // RL22

	property p_bad_rate;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!srk_pkg::rate_supported(speed, rate_q) |=> !lock_q;
	endproperty
	a_bad_rate: assert property (p_bad_rate) else $error("locked to unsupported rate"); // RL23

	property p_test_mode;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		speed == srk_pkg::SPD_TEST |=> !lock_q ##1 !lock_q;
	endproperty
	a_test_mode: assert property (p_test_mode) else $error("test mode locked"); // RL25

	property p_legs_opposite;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		pri_p_q != pri_n_q && sec_p_q != sec_n_q;
	endproperty
	a_legs_opposite: assert property (p_legs_opposite) else $error("output legs not opposite"); // RL24

	c_lock_sd: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) lock_q && def_q);
	c_lock_hd: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) lock_q && !def_q && !bypass);
	c_clk_out: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) clk_choose && lock_q && !mute);
	c_lost: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) $fell(lock_q) && lost);
endmodule : srk_reclocker_ctrl

// File: src/srk_pkg.sv
package srk_pkg;
	// Register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	// Control register fields
	localparam int CTRL_SPEED_LSB = 0;
	localparam int CTRL_PICK_LSB = 2;
	localparam int CTRL_SILENCE_BIT = 4;
	localparam int CTRL_SKIP_BIT = 5;
	localparam int CTRL_CLKSEL_BIT = 6;
	localparam int CTRL_FOLLOW_BIT = 7;
	localparam int CTRL_WIDTH = 8;
	// Pull-up on silence_n, pull-downs everywhere else
	localparam logic [7:0] CTRL_RST = 8'h10;
	// Status register fields
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_DEF_BIT = 1;
	localparam int STAT_BYPASS_BIT = 2;
	localparam int STAT_MUTE_BIT = 3;
	localparam int STAT_RATE_LSB = 4;
	localparam int STAT_ACT_BIT = 7;
	// Timing
	localparam int SYS_PERIOD_NS = 5;
	localparam int DEF_DELAY_NS = 37;
	localparam int DEF_CYCLES = (DEF_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int LOSS_TIME_NS = 1000000;
	localparam int LOSS_CYCLES = LOSS_TIME_NS / SYS_PERIOD_NS;

	typedef enum logic [1:0] {
		SPD_AUTO = 2'b00,
		SPD_270 = 2'b01,
		SPD_HD = 2'b10,
		SPD_TEST = 2'b11
	} srk_speed_t;

	typedef enum logic [2:0] {
		RATE_143 = 3'b000,
		RATE_270 = 3'b001,
		RATE_1483 = 3'b010,
		RATE_1485 = 3'b011,
		RATE_177 = 3'b100,
		RATE_360 = 3'b101,
		RATE_540 = 3'b110,
		RATE_NONE = 3'b111
	} srk_rate_t;

	typedef enum logic {
		LK_SEARCH = 1'b0,
		LK_LOCKED = 1'b1
	} srk_lock_st_t;

	// Rate accepted under the chosen speed mode
	function automatic logic rate_supported(input srk_speed_t spd, input srk_rate_t rate);
		case (spd)
			SPD_AUTO: rate_supported = (rate == RATE_143) || (rate == RATE_270) ||
				(rate == RATE_1483) || (rate == RATE_1485);
			SPD_270: rate_supported = (rate == RATE_270);
			SPD_HD: rate_supported = (rate == RATE_1483) || (rate == RATE_1485);
			default: rate_supported = 1'b0;
		endcase
	endfunction : rate_supported

	// Standard definition rates
	function automatic logic rate_is_sd(input srk_rate_t rate);
		rate_is_sd = (rate == RATE_143) || (rate == RATE_270);
	endfunction : rate_is_sd
endpackage : srk_pkg

// File: bench/srk_src_model.sv
`timescale 1ns/1ps
// Cable-side source plus an abstract clock recovery loop
module srk_src_model (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [3:0] noise_in,
	input wire logic active_in,
	input wire logic recov_run_in,
	input wire logic locked_in,
	input wire logic [2:0] rate_in,
	output logic serial_in_0_out,
	output logic serial_in_1_out,
	output logic serial_in_2_out,
	output logic serial_in_3_out,
	output logic recov_clk_out,
	output logic cdr_locked_out,
	output logic [2:0] cdr_rate_out
);
	logic [1:0] div_q;
	// A muted equalizer leaves a static low line, so activity really stops
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			{serial_in_3_out, serial_in_2_out, serial_in_1_out, serial_in_0_out} <= 4'h0;
		end else begin
			{serial_in_3_out, serial_in_2_out, serial_in_1_out, serial_in_0_out} <= active_in ? noise_in : 4'h0;
		end
	end
	// Recovered clock stands still while halted, to expose retiming
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			div_q <= 2'h0;
		end else if (recov_run_in) begin
			div_q <= div_q + 2'h1;
		end
	end
	assign recov_clk_out = div_q[1];
	assign cdr_locked_out = locked_in;
	assign cdr_rate_out = rate_in;
endmodule : srk_src_model

// File: bench/srk_reclocker_ctrl_test.sv
`timescale 1ns/1ps
module srk_reclocker_ctrl_test;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, d;
	logic pready, pslverr, e, q, lp, cls;
	logic [3:0] noise = 4'h0, sv;
	logic act = 1'b1, rrun = 1'b1, lck = 1'b1, byp_chk = 1'b0;
	logic [2:0] rate = 3'h1, crate;
	logic [1:0] pick = 2'h0;
	logic s0, s1, s2, s3, rclk, clk_lock, lock, dclass, pp, pn, sp, sn;
	logic hist[$];
	int n_fail = 0, checked = 0, seed = 46, since = 0, s, j, p, r;
	// Reference clock supplied by the system
	initial forever #2.5 clk = ~clk;
	assign sv = {s3, s2, s1, s0};
	srk_src_model srk_src_model_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .noise_in(noise), .active_in(act),
		.recov_run_in(rrun), .locked_in(lck), .rate_in(rate), .serial_in_0_out(s0), .serial_in_1_out(s1),
		.serial_in_2_out(s2), .serial_in_3_out(s3), .recov_clk_out(rclk), .cdr_locked_out(clk_lock),
		.cdr_rate_out(crate));
	srk_reclocker_ctrl #(.LOSS_CYCLES(50)) srk_reclocker_ctrl_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .serial_in_0_in(s0),
		.serial_in_1_in(s1), .serial_in_2_in(s2), .serial_in_3_in(s3), .recov_clk_in(rclk),
		.cdr_locked_in(clk_lock), .cdr_rate_in(crate), .lock_indicator_out(lock), .definition_class_out(dclass),
		.primary_output_p_out(pp), .primary_output_n_out(pn), .second_output_p_out(sp), .second_output_n_out(sn));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// One APB transfer; entered just after a rising edge, leaves one idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int i;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			end_of_test();
		end
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	function automatic logic exp_lock(input int sp_code, input int rt);
		case (sp_code)
			0: return rt < 4;
			1: return rt == 1;
			2: return rt == 2 || rt == 3;
			default: return 1'b0;
		endcase
	endfunction : exp_lock
	// Reference model: raw path delay, and class timing after each lock rise
	always @(posedge clk) begin
		noise <= 4'($random(seed));
		hist.push_front(sv[pick]);
		if (hist.size() > 5) hist.pop_back();
		if (byp_chk && hist.size() == 5) cmp(pp, hist[4]);
		if (lock === 1'b1 && lp !== 1'b1) begin
			since = 0;
			cls = rate < 3'h2;
		end else if (since < 20) begin
			since++;
		end
		if (rst_n === 1'b1 && lock === 1'b1) cmp(dclass, since >= 8 ? cls : 1'b0);
		else if (rst_n === 1'b1 && lp === 1'b0) cmp(dclass, 1'b0);
		lp = lock;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		cmp({pp, pn, sp, sn}, 4'b0101);
		apb(1'b0, srk_pkg::CTRL_OFS, 32'h0);
		cmp(d, 32'h10);
		cmp(32'(e), 32'h0);
		apb(1'b1, 12'h008, 32'hff);
		cmp(e, 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		cmp(32'(e), 32'h1);
		cmp(d, 32'h0);
		// Every speed code against in-mode, out-of-mode and refused rates
		for (s = 0; s < 4; s++) begin
			for (j = 0; j < 4; j++) begin
				r = (j == 3) ? 4 : j;
				rate <= 3'(r);
				apb(1'b1, srk_pkg::CTRL_OFS, 32'h10 | 32'(s));
				repeat (30) @(posedge clk);
				cmp(lock, exp_lock(s, r));
				apb(1'b0, srk_pkg::STAT_OFS, 32'h0);
				cmp(d, {24'h0, 1'b1, 3'(r), 1'b0, !exp_lock(s, r), exp_lock(s, r) && r < 2, exp_lock(s, r)});
			end
		end
		// Each input, alternately forced bypass and test mode
		for (p = 0; p < 4; p++) begin
			pick <= 2'(p);
			apb(1'b1, srk_pkg::CTRL_OFS, 32'h10 | 32'(p << 2) | ((p % 2) ? 32'h20 : 32'h03));
			repeat (6) @(posedge clk);
			byp_chk <= 1'b1;
			repeat (20) @(posedge clk);
			byp_chk <= 1'b0;
		end
		pick <= 2'h0;
		rate <= 3'h1;
		apb(1'b1, srk_pkg::CTRL_OFS, 32'h10);
		repeat (30) @(posedge clk);
		rrun <= 1'b0;
		repeat (10) @(posedge clk);
		q = pp;
		// Retimed output holds while the recovered clock stands still
		repeat (20) begin
			@(posedge clk);
			cmp(pp, q);
		end
		apb(1'b1, srk_pkg::CTRL_OFS, 32'h50);
		repeat (30) @(posedge clk);
		cmp({sp, sn}, {rclk, ~rclk});
		apb(1'b1, srk_pkg::CTRL_OFS, 32'h70);
		repeat (6) @(posedge clk);
		cmp({sp, sn}, 2'b01);
		rrun <= 1'b1;
		// Mute wins whatever skip says
		for (j = 0; j < 2; j++) begin
			apb(1'b1, srk_pkg::CTRL_OFS, j ? 32'h20 : 32'h00);
			repeat (4) @(posedge clk);
			cmp({pp, pn, sp, sn}, 4'b0101);
		end
		// Silence tied to lock, skip high: live but unretimed
		apb(1'b1, srk_pkg::CTRL_OFS, 32'hb0);
		repeat (30) @(posedge clk);
		cmp(lock, 1'b1);
		byp_chk <= 1'b1;
		repeat (20) @(posedge clk);
		byp_chk <= 1'b0;
		lck <= 1'b0;
		repeat (10) @(posedge clk);
		cmp({lock, pp, pn}, 3'b001);
		lck <= 1'b1;
		apb(1'b1, srk_pkg::CTRL_OFS, 32'h10);
		repeat (30) @(posedge clk);
		cmp(lock, 1'b1);
		act <= 1'b0;
		repeat (40) @(posedge clk);
		cmp(lock, 1'b1);
		repeat (20) @(posedge clk);
		cmp({lock, dclass}, 2'b00);
		end_of_test();
	end
endmodule : srk_reclocker_ctrl_test
